// ===== hw/tsc_pkg.sv
// constants for the reflectometry segment configuration bank
// assumes a 16-bit register port driven from the management logic clock
package tsc_pkg;
  localparam logic [15:0] OFF_SEG_CONTROL = 16'h0170;
  localparam logic [15:0] OFF_SPARE_A = 16'h0171;
  localparam logic [15:0] OFF_SPARE_B = 16'h0172;
  localparam logic [15:0] OFF_SEG_WINDOW = 16'h0173;
  localparam logic [15:0] RST_SEG_CONTROL = 16'h0410;
  localparam logic [15:0] RST_SEG_WINDOW = 16'h1304;
  // writable bits of the control word; everything else is reserved
  localparam logic [15:0] MASK_SEG_CONTROL = 16'h7770;
  localparam int SAME_CHAN_BIT = 14;
  localparam int PULSE_CHAN_BIT = 13;
  localparam int OFFSET_KEEP_BIT = 12;
  localparam int AVG_LSB = 8;
  localparam int AVG_W = 3;
  localparam int SPAN_LSB = 4;
  localparam int SPAN_W = 3;
  localparam int WLEN_LSB = 8;
  localparam int SKIP_LSB = 0;
  localparam int WIN_W = 8;
  localparam logic [2:0] AVG_CODE_RSVD = 3'h7;
  localparam logic [2:0] SPAN_FIRST = 3'h1;
  localparam logic [2:0] SPAN_LAST = 3'h5;
  localparam int AVG_CNT_W = 7;
endpackage : tsc_pkg

// ===== hw/tsc_win_if.sv
// carrier between the configuration bank and its capture window timer
// assumes both ends share one clock
interface tsc_win_if;
  logic start;
  logic tick;
  logic [7:0] skip;
  logic [7:0] length;
  logic active;
  logic done;
  modport ctrl (output start, output tick, output skip, output length, input active, input done);
  modport timer (input start, input tick, input skip, input length, output active, output done);
endinterface : tsc_win_if

// ===== hw/tsc_win.sv
// capture window timer: discards a lead of samples, then opens the window
// assumes tick marks one reflection sample on the same clock
module tsc_win
  import tsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  tsc_win_if.timer win
);
  typedef enum logic [1:0] {ST_IDLE, ST_SKIP, ST_CAPT} tsc_state_type;
  tsc_state_type state_ff;
  tsc_state_type nxt_state;
  logic [WIN_W-1:0] cnt_ff;
  logic [WIN_W-1:0] nxt_cnt;
  logic active_ff;
  logic done_ff;
  logic nxt_done;
  wire cnt_last = (cnt_ff == 8'h01);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing; a zero skip or zero length simply falls through
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (win.start && win.skip != 8'h00)
        begin
          nxt_state = ST_SKIP;
          nxt_cnt = win.skip;
        end
        else if (win.start && win.length != 8'h00)
        begin
          nxt_state = ST_CAPT;
          nxt_cnt = win.length;
        end
        else if (win.start)
          nxt_done = 1'b1;
      end
      ST_SKIP:
      begin
        if (win.tick && cnt_last && win.length != 8'h00)
        begin
          nxt_state = ST_CAPT;
          nxt_cnt = win.length;
        end
        else if (win.tick && cnt_last)
        begin
          nxt_state = ST_IDLE;
          nxt_done = 1'b1;
        end
        else if (win.tick)
          nxt_cnt = cnt_ff - 8'h01;
      end
      ST_CAPT:
      begin
        if (win.tick && cnt_last)
        begin
          nxt_state = ST_IDLE;
          nxt_done = 1'b1;
        end
        else if (win.tick)
          nxt_cnt = cnt_ff - 8'h01;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      active_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      active_ff <= (nxt_state == ST_CAPT);
      done_ff <= nxt_done;
    end
  end

  assign win.active = active_ff;
  assign win.done = done_ff;

  ////////////////////////////////////////////////////////////////////////////
  property p_skip_holds_off;
    @(posedge clk_in) disable iff (rst_in)
      (state_ff == ST_IDLE && win.start && win.skip > 8'h01) |=> !active_ff [*2];
  endproperty
  a_skip_holds_off: assert property (p_skip_holds_off) else $error("window opened during skip");

  property p_window_closes;
    @(posedge clk_in) disable iff (rst_in)
      (state_ff == ST_CAPT && win.tick && cnt_last) |=> (!active_ff && done_ff);
  endproperty
  a_window_closes: assert property (p_window_closes) else $error("window did not close");

  property p_done_pulse;
    @(posedge clk_in) disable iff (rst_in) done_ff |=> !done_ff;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
endmodule : tsc_win

// ===== hw/tsc_top.sv
// reflectometry segment configuration bank with its capture window timer
// assumes register strobes and run controls come from logic on clk_in
// Overview of operation
// - with the same-channel bit clear the listen channel is the other one, else the pulse one.
// - the pulse goes on channel A when the pick bit is 0 and on B when 1, resetting to 0.
// - with the offset keep bit set, no DC removal reset is issued at the start of a run.
// - averaging spans 2 to the power of the code, codes 0-6 give 1-64, 7 reserved, reset 16.
// - the span pick selects the segment, codes 1 to 5 valid and 0, 6, 7 reserved.
// - the window length sets how many samples the segment capture lasts, reset 0x13.
// - the lead skip sets samples discarded before the window opens, reset 0x4.
module tsc_top
  import tsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic run_start_in,
  input wire logic sample_tick_in,
  output logic [15:0] reg_rdata_out,
  output logic pulse_chan_b_out,
  output logic listen_chan_b_out,
  output logic dc_rem_init_out,
  output logic [6:0] avg_cycles_out,
  output logic avg_code_rsvd_out,
  output logic [2:0] span_sel_out,
  output logic span_valid_out,
  output logic win_active_out,
  output logic win_done_out
);
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] off);
    addr_hit = (addr == off);
  endfunction : addr_hit

  logic [15:0] ctrl_ff;
  logic [15:0] window_ff;
  logic [15:0] rdata_ff;
  logic pulse_b_ff;
  logic listen_b_ff;
  logic dc_init_ff;
  logic [6:0] avg_ff;
  logic avg_rsvd_ff;
  logic [2:0] span_ff;
  logic span_ok_ff;
  logic active_ff;
  logic done_ff;
  tsc_win_if win_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode and field selection
  wire hit_ctrl = addr_hit(reg_addr_in, OFF_SEG_CONTROL);
  wire hit_window = addr_hit(reg_addr_in, OFF_SEG_WINDOW);
  wire [15:0] nxt_ctrl = (reg_wdata_in & MASK_SEG_CONTROL);
  wire [15:0] nxt_rdata = hit_ctrl ? ctrl_ff : (hit_window ? window_ff : 16'h0000);
  wire same_chan = ctrl_ff[SAME_CHAN_BIT];
  wire pulse_b = ctrl_ff[PULSE_CHAN_BIT];
  wire offset_filter_keep = ctrl_ff[OFFSET_KEEP_BIT];
  wire [AVG_W-1:0] avg_code = ctrl_ff[AVG_LSB +: AVG_W];
  wire [SPAN_W-1:0] span_code = ctrl_ff[SPAN_LSB +: SPAN_W];
  wire nxt_listen_b = same_chan ? pulse_b : ~pulse_b;
  // reserved average code yields no cycle count rather than a guessed one
  wire [6:0] nxt_avg = (avg_code == AVG_CODE_RSVD) ? 7'h00 : (7'h01 << avg_code);
  wire nxt_span_ok = (span_code >= SPAN_FIRST) && (span_code <= SPAN_LAST);
  // a run on a reserved span never opens a window
  wire run_go = run_start_in && nxt_span_ok;

  assign win_bus.start = run_go;
  assign win_bus.tick = sample_tick_in;
  assign win_bus.length = window_ff[WLEN_LSB +: WIN_W];
  assign win_bus.skip = window_ff[SKIP_LSB +: WIN_W];

  tsc_win u_win (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .win (win_bus.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file; spare offsets store nothing
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_ff <= RST_SEG_CONTROL;
      window_ff <= RST_SEG_WINDOW;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      if (reg_wr_in && hit_ctrl)
        ctrl_ff <= nxt_ctrl;
      if (reg_wr_in && hit_window)
        window_ff <= reg_wdata_in;
      if (reg_rd_in)
        rdata_ff <= nxt_rdata;
    end
  end

  // registered outputs toward the reflection engine
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pulse_b_ff <= 1'b0;
      listen_b_ff <= 1'b1;
      dc_init_ff <= 1'b0;
      avg_ff <= 7'h10;
      avg_rsvd_ff <= 1'b0;
      span_ff <= 3'h1;
      span_ok_ff <= 1'b1;
      active_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      pulse_b_ff <= pulse_b;
      listen_b_ff <= nxt_listen_b;
      dc_init_ff <= run_go && !offset_filter_keep;
      avg_ff <= nxt_avg;
      avg_rsvd_ff <= (avg_code == AVG_CODE_RSVD);
      span_ff <= span_code;
      span_ok_ff <= nxt_span_ok;
      active_ff <= win_bus.active;
      done_ff <= win_bus.done;
    end
  end

  assign reg_rdata_out = rdata_ff;
  assign pulse_chan_b_out = pulse_b_ff;
  assign listen_chan_b_out = listen_b_ff;
  assign dc_rem_init_out = dc_init_ff;
  assign avg_cycles_out = avg_ff;
  assign avg_code_rsvd_out = avg_rsvd_ff;
  assign span_sel_out = span_ff;
  assign span_valid_out = span_ok_ff;
  assign win_active_out = active_ff;
  assign win_done_out = done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks on what the bank drives toward the engine and back onto the bus
  property p_listen_choice;
    @(posedge clk_in) disable iff (rst_in)
      ##1 listen_chan_b_out == ($past(same_chan) ? $past(pulse_b) : !$past(pulse_b));
  endproperty
  a_listen_choice: assert property (p_listen_choice) else $error("wrong listen channel");

  property p_pulse_chan;
    @(posedge clk_in) disable iff (rst_in)
      (reg_wr_in && hit_ctrl) |-> ##2 pulse_chan_b_out == $past(reg_wdata_in[PULSE_CHAN_BIT], 2);
  endproperty
  a_pulse_chan: assert property (p_pulse_chan) else $error("pulse channel not applied");

  property p_keep_offset;
    @(posedge clk_in) disable iff (rst_in)
      (run_start_in && offset_filter_keep) |=> !dc_rem_init_out;
  endproperty
  a_keep_offset: assert property (p_keep_offset) else $error("dc removal reset while kept");

  property p_avg_count;
    @(posedge clk_in) disable iff (rst_in)
      (avg_code == 3'h6) |=> (avg_cycles_out == 7'h40);
  endproperty
  a_avg_count: assert property (p_avg_count) else $error("average count wrong");

  property p_span_rsvd;
    @(posedge clk_in) disable iff (rst_in)
      (span_code == 3'h0 || span_code > 3'h5) |=> !span_valid_out;
  endproperty
  a_span_rsvd: assert property (p_span_rsvd) else $error("reserved span accepted");

  property p_rsvd_read;
    @(posedge clk_in) disable iff (rst_in)
      (reg_rd_in && !hit_ctrl && !hit_window) |=> (reg_rdata_out == 16'h0000);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved space read nonzero");

  // a kept offset filter or a reserved span code must be the only things that suppress the clear request
  property p_dc_issue;
    @(posedge clk_in) disable iff (rst_in)
      (run_start_in && nxt_span_ok && !offset_filter_keep) |=> dc_rem_init_out;
  endproperty
  a_dc_issue: assert property (p_dc_issue) else $error("dc reset missing");

  property p_avg_rsvd;
    @(posedge clk_in) disable iff (rst_in)
      (avg_code == AVG_CODE_RSVD) |=> (avg_code_rsvd_out && avg_cycles_out == 7'h00);
  endproperty
  a_avg_rsvd: assert property (p_avg_rsvd) else $error("reserved average code used");

  property p_span_ok;
    @(posedge clk_in) disable iff (rst_in)
      (span_code >= 3'h1 && span_code <= 3'h5) |=> span_valid_out;
  endproperty
  a_span_ok: assert property (p_span_ok) else $error("valid span refused");

  property p_run_refused;
    @(posedge clk_in) disable iff (rst_in)
      (run_start_in && !nxt_span_ok) |=> !dc_rem_init_out;
  endproperty
  a_run_refused: assert property (p_run_refused) else $error("run on reserved span");

  property p_ctrl_read;
    @(posedge clk_in) disable iff (rst_in)
      (reg_rd_in && hit_ctrl) |=> ((reg_rdata_out & ~MASK_SEG_CONTROL) == 16'h0000);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("reserved control bit set");

  property p_window_read;
    @(posedge clk_in) disable iff (rst_in)
      (reg_rd_in && hit_window) |=> (reg_rdata_out == $past(window_ff));
  endproperty
  a_window_read: assert property (p_window_read) else $error("window word read wrong");

  property p_done_closed;
    @(posedge clk_in) disable iff (rst_in)
      win_done_out |-> !win_active_out;
  endproperty
  a_done_closed: assert property (p_done_closed) else $error("done while window open");
endmodule : tsc_top

// ===== tb/tdr_segment_config_tb.sv
// self-checking bench for the segment configuration bank
// assumes the bank alone, inputs driven on falling clock edges
module tdr_segment_config_tb
  import tsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in, reg_wr_in, reg_rd_in, run_start_in, sample_tick_in;
  logic [15:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic pulse_b, listen_b, dc_init, avg_rsvd, span_ok, win_act, win_done;
  logic [6:0] avg_cyc;
  logic [2:0] span;
  int bad_count = 0;
  int checks = 0;

  tsc_top u_tsc_top (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in),
    .run_start_in(run_start_in),
    .sample_tick_in(sample_tick_in),
    .reg_rdata_out(reg_rdata_out),
    .pulse_chan_b_out(pulse_b),
    .listen_chan_b_out(listen_b),
    .dc_rem_init_out(dc_init),
    .avg_cycles_out(avg_cyc),
    .avg_code_rsvd_out(avg_rsvd),
    .span_sel_out(span),
    .span_valid_out(span_ok),
    .win_active_out(win_act),
    .win_done_out(win_done)
  );

  ////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic stop_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // outputs settle one edge after the write edge
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask : reg_wr

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    @(negedge clk_in);
    chk(reg_rdata_out, exp);
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(OFF_SEG_CONTROL, 16'h0410);
    rd_chk(OFF_SEG_WINDOW, 16'h1304);
    rd_chk(OFF_SPARE_A, 16'h0000);
    rd_chk(OFF_SPARE_B, 16'h0000);
    chk(pulse_b, 16'h0000);
    chk(listen_b, 16'h0001);
    chk(avg_cyc, 16'h0010);
    chk(span, 16'h0001);
    chk(span_ok, 16'h0001);
    chk(avg_rsvd, 16'h0000);
    chk(dc_init, 16'h0000);
    chk(win_act, 16'h0000);
    $display("end t_reset");
  endtask : t_reset

  // every pairing of pulse pick and same-channel listen
  task automatic t_chan();
    logic [1:0] i;
    for (int k = 0; k < 4; k++)
    begin
      i = 2'(k);
      reg_wr(OFF_SEG_CONTROL, 16'h0410 | (16'(i) << 13));
      chk(pulse_b, 16'(i[0]));
      chk(listen_b, 16'(i[1] ? i[0] : !i[0]));
    end
    $display("end t_chan");
  endtask : t_chan

  // all average codes, reserved code 7 included
  task automatic t_avg();
    for (int c = 0; c < 8; c++)
    begin
      reg_wr(OFF_SEG_CONTROL, 16'h0010 | 16'(c << 8));
      chk(avg_cyc, (c == 7) ? 16'h0000 : 16'(1 << c));
      chk(avg_rsvd, 16'(c == 7));
      rd_chk(OFF_SEG_CONTROL, 16'h0010 | 16'(c << 8));
    end
    $display("end t_avg");
  endtask : t_avg

  task automatic t_span();
    for (int s = 0; s < 8; s++)
    begin
      reg_wr(OFF_SEG_CONTROL, 16'h0400 | 16'(s << 4));
      chk(span, 16'(s));
      chk(span_ok, 16'(s >= 1 && s <= 5));
    end
    $display("end t_span");
  endtask : t_span

  // reserved bits and spare words stay zero
  task automatic t_rsvd();
    reg_wr(OFF_SEG_CONTROL, 16'hFFFF);
    rd_chk(OFF_SEG_CONTROL, 16'h7770);
    reg_wr(OFF_SPARE_A, 16'hFFFF);
    reg_wr(OFF_SPARE_B, 16'hFFFF);
    rd_chk(OFF_SPARE_A, 16'h0000);
    rd_chk(OFF_SPARE_B, 16'h0000);
    rd_chk(16'h0174, 16'h0000);
    rd_chk(OFF_SEG_CONTROL, 16'h7770);
    $display("end t_rsvd");
  endtask : t_rsvd

  // one sample tick per cycle from the edge after start
  task automatic run(input int skip, input int len, input logic keep, input logic ok);
    int dcat;
    int first;
    int cnt;
    logic done;
    dcat = 0;
    first = 0;
    cnt = 0;
    done = 1'b0;
    run_start_in = 1'b1;
    @(negedge clk_in);
    run_start_in = 1'b0;
    sample_tick_in = 1'b1;
    // the clear request stands only in the cycle after the start edge
    if (dc_init === 1'b1) dcat = 1;
    for (int i = 1; i < (ok ? 600 : 20) && !done; i++)
    begin
      @(negedge clk_in);
      if (dc_init === 1'b1 && dcat == 0) dcat = i + 1;
      if (win_act === 1'b1 && first == 0) first = i;
      if (win_act === 1'b1) cnt++;
      if (win_done === 1'b1) done = 1'b1;
    end
    sample_tick_in = 1'b0;
    @(negedge clk_in);
    chk(16'(dcat), (ok && !keep) ? 16'h0001 : 16'h0000);
    chk(16'(first), ok ? 16'(skip + 1) : 16'h0000);
    chk(16'(cnt), ok ? 16'(len) : 16'h0000);
    chk(done, 16'(ok));
    if (ok && !done) stop_test();
  endtask : run

  task automatic t_run();
    reg_wr(OFF_SEG_WINDOW, 16'h1A21);
    rd_chk(OFF_SEG_WINDOW, 16'h1A21);
    reg_wr(OFF_SEG_CONTROL, 16'h0430);
    run(33, 26, 1'b0, 1'b1);
    reg_wr(OFF_SEG_WINDOW, 16'h8F6F);
    reg_wr(OFF_SEG_CONTROL, 16'h1450);
    run(111, 143, 1'b1, 1'b1);
    // a zero lead skip opens the window on the first sample
    reg_wr(OFF_SEG_WINDOW, 16'h0D00);
    run(0, 13, 1'b1, 1'b1);
    // reserved span code: the run must be refused
    reg_wr(OFF_SEG_CONTROL, 16'h0400);
    run(0, 0, 1'b0, 1'b0);
    $display("end t_run");
  endtask : t_run

  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst_in = 1'b1;
    reg_addr_in = 16'h0000;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    run_start_in = 1'b0;
    sample_tick_in = 1'b0;
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    t_reset();
    t_chan();
    t_avg();
    t_span();
    t_rsvd();
    t_run();
    stop_test();
  end
endmodule : tdr_segment_config_tb
